// ===== hw/pbs_defs.svh
// Constants for the pipelined burst SRAM port
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_ADDR_W    10
`define PBS_LANES     4
`define PBS_LANE_W    9
`define PBS_DATA_BITS 8
`define PBS_BUS_W     36
`define PBS_DEPTH     1024
`define PBS_BURST_W   2
`endif

// ===== hw/pbs_pkg.sv
// Types shared by the pipelined burst SRAM port
`include "pbs_defs.svh"
package pbs_pkg;
  typedef logic [`PBS_ADDR_W-1:0]  pbs_addr_t;
  typedef logic [`PBS_BUS_W-1:0]   pbs_word_t;
  typedef logic [`PBS_LANES-1:0]   pbs_lanes_t;
  typedef logic [`PBS_BURST_W-1:0] pbs_burst_t;
  typedef enum logic [1:0] {
    PBS_IDLE  = 2'b00,
    PBS_READ  = 2'b01,
    PBS_WRITE = 2'b10,
    PBS_SLEEP = 2'b11
  } pbs_state_t;
endpackage : pbs_pkg

// ===== hw/pbs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // First stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : pbs_sync

// ===== hw/pbs_mem.sv
// Byte-lane memory array with registered read data
`timescale 1ns/10ps
`include "pbs_defs.svh"
module pbs_mem
  import pbs_pkg::*;
(
  input  wire logic       clk,
  input  wire pbs_addr_t  addr,
  input  wire pbs_lanes_t wr_lane,
  input  wire pbs_word_t  wr_data,
  input  wire logic       rd_en,
  output pbs_word_t       rd_data
);
  pbs_word_t rd_q;

  // Each lane owns its array and strobe, so every process is the only writer of
  // its storage; contents never reset
  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g++) begin : g_lane
      logic [`PBS_LANE_W-1:0] lane_mem [`PBS_DEPTH];
      always_ff @(posedge clk) begin
        if (wr_lane[g]) begin
          lane_mem[addr] <= wr_data[g*`PBS_LANE_W +: `PBS_LANE_W];
        end
        if (rd_en) begin
          rd_q[g*`PBS_LANE_W +: `PBS_LANE_W] <= lane_mem[addr];
        end
      end
    end
  endgenerate

  assign rd_data = rd_q;
endmodule : pbs_mem

// ===== hw/pbs_port.sv
// Top of the pipelined burst SRAM port
// What this block does
// R1: All synchronous inputs are captured only on the rising clock edge.
// R2: Low burst advance during a burst steps the burst counter.
// R3: First chip select is active low and sampled on the rising edge.
// R4: Second select active high, third active low; selected only when all active.
// R5: Processor strobe is ignored while first chip select is high.
// R6: Output enable acts asynchronously; low drives data, high floats pins as inputs.
// R7: First read clock after deselect keeps pins floating regardless of output enable.
// R8: Asserted advance moves to next burst location without new external address.
// R9: Processor strobe loads the address register and bits [1:0] into the counter.
// R10: Controller strobe loads the address register and seeds counter from [1:0].
// R11: With both strobes low and first chip select low, only the processor strobe is acted upon.
// R12: Burst order strap low selects linear, high selects interleaved order.
// R13: Sleep input puts the port in low power while keeping memory contents.
// R14: Data pins used as inputs feed the array unregistered and are written on the write edge.
// R15: Read data is from the address registered at the previous edge.
// R16: Each byte lane is eight data bits plus one parity bit.
// R17: Low global write writes every byte regardless of byte controls.
// R18: A byte select writes its lane only with byte write enable low.
// R19: Two-bit wrapping burst counter; first burst address held for the access.
// R20: Linear adds step modulo four; interleaved XORs start bits with step.
`timescale 1ns/10ps
`include "pbs_defs.svh"
module pbs_port
  import pbs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire pbs_addr_t               addr,
  input  wire logic                    chip_sel_primary_n,
  input  wire logic                    chip_sel_secondary,
  input  wire logic                    chip_sel_tertiary_n,
  input  wire logic                    proc_addr_strobe_n,
  input  wire logic                    ctrl_addr_strobe_n,
  input  wire logic                    burst_advance_n,
  input  wire logic                    all_bytes_write_n,
  input  wire logic                    byte_write_enable_n,
  input  wire pbs_lanes_t              byte_lane_select_n,
  input  wire logic                    output_enable_n,
  input  wire logic                    burst_order_sel,
  input  wire logic                    sleep_req,
  input  wire logic [`PBS_LANES*`PBS_DATA_BITS-1:0] byte_lane_data_in,
  input  wire pbs_lanes_t              byte_lane_parity_in,
  output logic [`PBS_LANES*`PBS_DATA_BITS-1:0] byte_lane_data_out,
  output pbs_lanes_t                   byte_lane_parity_out,
  output logic                         data_oe,
  output logic                         sleeping
);

  // Sleep and the strap come from pins outside the clock domain
  logic sleep_s;
  logic order_s;
  logic [1:0] async_s;

  pbs_sync #(.W(2)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({sleep_req, burst_order_sel}),
    .sync_out (async_s)
  );
  assign sleep_s = async_s[1];
  assign order_s = async_s[0];

  // Burst address step; a function since linear and interleaved share it
  function automatic pbs_burst_t burst_addr(input pbs_burst_t start, input pbs_burst_t step,
                                            input logic interleave);
    if (interleave) begin
      burst_addr = start ^ step; // [R20]
    end else begin
      burst_addr = start + step; // [R20]
    end
  endfunction : burst_addr

  // Pack lane data and parity into nine-bit lanes
  function automatic pbs_word_t pack_lanes(input logic [`PBS_LANES*`PBS_DATA_BITS-1:0] d,
                                           input pbs_lanes_t p);
    pack_lanes = '0;
    for (int i = 0; i < `PBS_LANES; i++) begin
      pack_lanes[i*`PBS_LANE_W +: `PBS_LANE_W] = {p[i], d[i*`PBS_DATA_BITS +: `PBS_DATA_BITS]}; // [R16]
    end
  endfunction : pack_lanes

  // Registered control state and the memory port signals
  pbs_state_t state_q, state_d;
  pbs_addr_t  addr_q, addr_d;
  pbs_burst_t start_q, start_d;
  pbs_burst_t step_q, step_d;
  logic       order_q, order_d;
  logic       mask_q, mask_d;
  logic       rd_valid_q, rd_valid_d;
  logic       sel_q, sel_d;
  pbs_word_t  wr_word;
  pbs_lanes_t wr_lane;
  logic       rd_en;
  pbs_addr_t  mem_addr;
  pbs_word_t  rd_data;

  // Decode of the sampled pins
  logic selected;
  logic proc_go;
  logic ctrl_go;
  logic wr_req;
  pbs_lanes_t lane_req;

  always_comb begin
    selected = !chip_sel_primary_n && chip_sel_secondary && !chip_sel_tertiary_n; // [R3] [R4]
    proc_go  = !proc_addr_strobe_n && !chip_sel_primary_n; // [R5]
    // A processor strobe that is ignored leaves the controller strobe free to deselect
    ctrl_go  = !ctrl_addr_strobe_n && !proc_go; // [R11]
    if (!all_bytes_write_n) begin
      lane_req = '1; // [R17]
    end else if (!byte_write_enable_n) begin
      lane_req = ~byte_lane_select_n; // [R18]
    end else begin
      lane_req = '0;
    end
    wr_req = |lane_req;
  end

  // Next-state logic for the access sequencer
  always_comb begin
    state_d    = state_q;
    addr_d     = addr_q;
    start_d    = start_q;
    step_d     = step_q;
    order_d    = order_q;
    mask_d     = 1'b0;
    rd_valid_d = 1'b0;
    sel_d      = sel_q;
    wr_word    = pack_lanes(byte_lane_data_in, byte_lane_parity_in); // [R14]
    wr_lane    = '0;
    rd_en      = 1'b0;
    mem_addr   = {addr_q[`PBS_ADDR_W-1:`PBS_BURST_W], burst_addr(start_q, step_q, order_q)};
    if (sleep_s) begin
      // Sleep drops any access; the array keeps its contents
      state_d = PBS_SLEEP; // [R13]
      sel_d   = 1'b0;
    end else if (proc_go || ctrl_go) begin
      // New access: load address and seed counter from the low bits [R9] [R10]
      if (selected) begin
        addr_d   = addr;
        start_d  = addr[`PBS_BURST_W-1:0]; // [R19]
        step_d   = '0;
        order_d  = order_s; // [R12]
        mem_addr = addr;
        sel_d    = 1'b1;
        if (ctrl_go && wr_req) begin
          // Controller-strobe write completes in one cycle
          state_d = PBS_WRITE;
          wr_lane = lane_req;
        end else if (proc_go) begin
          // Processor-strobe access: write controls are ignored in this cycle
          state_d    = PBS_READ;
          rd_en      = 1'b1;
          rd_valid_d = 1'b1;
          mask_d     = !sel_q; // [R7]
        end else begin
          state_d    = PBS_READ;
          rd_en      = 1'b1;
          rd_valid_d = 1'b1;
          mask_d     = !sel_q; // [R7]
        end
      end else begin
        state_d = PBS_IDLE;
        sel_d   = 1'b0;
      end
    end else begin
      unique case (state_q)
        PBS_IDLE: begin
          // No access open, so advance and write controls mean nothing
          state_d = PBS_IDLE;
        end
        PBS_READ, PBS_WRITE: begin
          // Burst cycle: an advance moves the counter, never the external address
          if (!burst_advance_n) begin
            step_d   = step_q + 2'h1; // [R2] [R8] [R19]
            mem_addr = {addr_q[`PBS_ADDR_W-1:`PBS_BURST_W], burst_addr(start_q, step_d, order_q)};
          end
          if (wr_req) begin
            state_d = PBS_WRITE;
            wr_lane = lane_req; // [R17] [R18]
          end else begin
            state_d    = PBS_READ;
            rd_en      = 1'b1;
            rd_valid_d = 1'b1;
          end
        end
        PBS_SLEEP: begin
          // Wake into idle; the next access must be strobed afresh
          state_d = PBS_IDLE;
        end
      endcase
    end
  end

  // Every control register samples on the rising edge only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= PBS_IDLE;
      addr_q     <= '0;
      start_q    <= '0;
      step_q     <= '0;
      order_q    <= 1'b0;
      mask_q     <= 1'b0;
      rd_valid_q <= 1'b0;
      sel_q      <= 1'b0;
    end else begin
      state_q    <= state_d; // [R1]
      addr_q     <= addr_d;
      start_q    <= start_d;
      step_q     <= step_d;
      order_q    <= order_d;
      mask_q     <= mask_d;
      rd_valid_q <= rd_valid_d;
      sel_q      <= sel_d;
    end
  end

  // Write data takes the live pins so a one-cycle write lands this edge
  pbs_mem u_mem (
    .clk     (clk),
    .addr    (mem_addr),
    .wr_lane (wr_lane),
    .wr_data (wr_word),
    .rd_en   (rd_en),
    .rd_data (rd_data)
  );

  // Unpack registered read data back to lane ports
  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g++) begin : g_out
      assign byte_lane_data_out[g*`PBS_DATA_BITS +: `PBS_DATA_BITS] =
        rd_data[g*`PBS_LANE_W +: `PBS_DATA_BITS]; // [R15]
      assign byte_lane_parity_out[g] = rd_data[g*`PBS_LANE_W + `PBS_DATA_BITS]; // [R16]
    end
  endgenerate

  // Output enable is combinational so it acts without the clock; the
  // deselect mask and write cycles still hold the pins off
  assign data_oe  = !output_enable_n && rd_valid_q && !mask_q && !sleep_s; // [R6] [R7]
  assign sleeping = (state_q == PBS_SLEEP);
endmodule : pbs_port

// ===== tb/pbs_port_monitor.sv
// Pin-level checks for the pipelined burst SRAM port
`timescale 1ns/10ps
module pbs_port_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        chip_sel_primary_n,
  input wire logic        chip_sel_secondary,
  input wire logic        chip_sel_tertiary_n,
  input wire logic        proc_addr_strobe_n,
  input wire logic        ctrl_addr_strobe_n,
  input wire logic        burst_advance_n,
  input wire logic        output_enable_n,
  input wire logic        sleep_req,
  input wire logic [31:0] byte_lane_data_out,
  input wire logic        data_oe,
  input wire logic        sleeping
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Access kinds seen at the pins; deselect is keyed on the controller strobe only
  wire sel  = !chip_sel_primary_n && chip_sel_secondary && !chip_sel_tertiary_n;
  wire rd   = !proc_addr_strobe_n && sel;
  wire nop  = proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n;
  wire cdes = !ctrl_addr_strobe_n && !sel;
  oe_float_a: assert property (output_enable_n |-> !data_oe)
    else $error("data driven with output enable high");
  desel_pri_a: assert property (cdes && chip_sel_primary_n |-> ##2 !data_oe)
    else $error("outputs on after primary deselect");
  desel_sec_a: assert property (cdes && !chip_sel_primary_n |-> ##2 !data_oe)
    else $error("outputs on after secondary deselect");
  idle_read_a: assert property (cdes ##1 rd |-> ##1 !data_oe)
    else $error("outputs on in first read after deselect");
  rd_drive_a: assert property (rd ##1 rd |-> ##1 output_enable_n || data_oe)
    else $error("outputs off in back to back read");
  hold_data_a: assert property (rd ##1 nop [*2] |=> $stable(byte_lane_data_out))
    else $error("read data moved without access");
  sleep_in_a: assert property (sleep_req [*4] |=> sleeping)
    else $error("sleep not entered");
  sleep_out_a: assert property (!sleep_req [*4] |=> !sleeping)
    else $error("sleep not left");
endmodule : pbs_port_monitor

// ===== tb/pbs_host.sv
// Controller-side model driving the port's strobes, selects, write controls and data
`timescale 1ns/10ps
module pbs_host
  import pbs_pkg::*;
(
  input  wire logic   clk,
  output pbs_addr_t   addr,
  output logic        chip_sel_primary_n,
  output logic        chip_sel_secondary,
  output logic        chip_sel_tertiary_n,
  output logic        proc_addr_strobe_n,
  output logic        ctrl_addr_strobe_n,
  output logic        burst_advance_n,
  output logic        all_bytes_write_n,
  output logic        byte_write_enable_n,
  output pbs_lanes_t  byte_lane_select_n,
  output logic [31:0] byte_lane_data_in,
  output pbs_lanes_t  byte_lane_parity_in
);
  // Quiet bus at time zero: nothing strobed, device selected
  initial begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
    {all_bytes_write_n, byte_write_enable_n, byte_lane_select_n} = 6'h3F;
    {chip_sel_primary_n, chip_sel_secondary, chip_sel_tertiary_n} = 3'h2;
    addr = 10'h000;
    {byte_lane_parity_in, byte_lane_data_in} = 36'h0;
  end
  // One bus cycle set up on the falling edge; ctl is {proc, ctrl, adv, all, bwe}, low active
  task automatic cyc(input logic [4:0] ctl, input pbs_lanes_t sel_n, input logic [2:0] cs,
                     input pbs_addr_t a, input pbs_word_t w);
    @(negedge clk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = ctl[4:2];
    all_bytes_write_n = ctl[1];
    {byte_write_enable_n, byte_lane_select_n} = {ctl[0], sel_n};
    {chip_sel_primary_n, chip_sel_secondary, chip_sel_tertiary_n} = cs;
    addr = a;
    {byte_lane_parity_in, byte_lane_data_in} = w;
  endtask : cyc
  // Idle cycle; released data lines flip so a stale value never passes for data
  task automatic nop();
    cyc(5'h1F, 4'hF, 3'h2, addr, ~{byte_lane_parity_in, byte_lane_data_in});
  endtask : nop
endmodule : pbs_host

// ===== tb/pbs_port_bench.sv
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/10ps
module pbs_port_bench
  import pbs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        output_enable_n = 1'b0;
  logic        burst_order_sel = 1'b0;
  logic        sleep_req = 1'b0;
  pbs_addr_t   addr;
  pbs_lanes_t  byte_lane_select_n, byte_lane_parity_in, byte_lane_parity_out;
  logic [31:0] byte_lane_data_in, byte_lane_data_out;
  logic        chip_sel_primary_n, chip_sel_secondary, chip_sel_tertiary_n, data_oe, sleeping;
  logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
  logic        all_bytes_write_n, byte_write_enable_n;
  int          err_total = 0;
  int          checks = 0;
  localparam logic [2:0] ON = 3'h2;
  wire pbs_word_t q = {byte_lane_parity_out, byte_lane_data_out};
  pbs_port u_dut (.*);
  pbs_host u_host (.*);
  always #2 clk = ~clk;
  // Pattern stored at each address, parity lanes included
  function automatic pbs_word_t wv(input pbs_addr_t x);
    return {x[3:0], 22'h2A5A5A, x};
  endfunction : wv
  task automatic chk(input string n, input pbs_word_t e, input pbs_word_t s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic gw(input pbs_addr_t a, input pbs_word_t w);
    u_host.cyc(5'h15, 4'hF, ON, a, w);
  endtask : gw
  // Single read; data stands from the taking edge and is looked at in the next cycle
  task automatic rd(input string n, input pbs_addr_t a, input pbs_word_t e);
    u_host.cyc(5'h0F, 4'hF, ON, a, 36'h0);
    u_host.nop();
    chk(n, e, q);
    @(negedge clk);
  endtask : rd
  task automatic t_fill();
    for (int i = 0; i < 4; i++) gw(10'h020 + 10'(i), wv(10'h020 + 10'(i)));
    gw(10'h050, wv(10'h050));
    rd("fill", 10'h022, wv(10'h022));
  endtask : t_fill
  // Lanes 0 and 2 selected; all four selects without byte enable must not write
  task automatic t_bytes();
    pbs_word_t m = {4'h5, 32'h00FF00FF};
    gw(10'h040, wv(10'h040));
    u_host.cyc(5'h16, 4'hA, ON, 10'h040, ~wv(10'h040));
    u_host.cyc(5'h17, 4'h0, ON, 10'h040, 36'h0);
    rd("byte lanes", 10'h040, (wv(10'h040) & ~m) | (~wv(10'h040) & m));
  endtask : t_bytes
  task automatic t_sel();
    logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
    foreach (cs[i]) u_host.cyc(5'h15, 4'hF, cs[i], 10'h050, 36'h0);
    rd("deselected write", 10'h050, wv(10'h050));
  endtask : t_sel
  // Both strobes with global write low: processor strobe wins, so it is a read
  task automatic t_both();
    u_host.cyc(5'h05, 4'hF, ON, 10'h050, 36'h0);
    u_host.nop();
    @(negedge clk);
    chk("both strobes", wv(10'h050), q);
    rd("both strobes kept", 10'h050, wv(10'h050));
  endtask : t_both
  // Burst from offset 1 while the external address wanders off
  task automatic t_burst(input logic il);
    burst_order_sel = il;
    repeat (4) @(negedge clk);
    u_host.cyc(5'h0F, 4'hF, ON, 10'h021, 36'h0);
    for (int i = 0; i < 5; i++) begin
      int s;
      u_host.cyc(i < 3 ? 5'h1B : 5'h1F, 4'hF, ON, 10'h3FF, 36'h0);
      // Advances already taken by now; three at most
      s = (i > 3) ? 3 : i;
      chk("burst", wv({8'h08, il ? 2'(1 ^ s) : 2'(1 + s)}), q);
    end
  endtask : t_burst
  task automatic t_first();
    u_host.cyc(5'h17, 4'hF, 3'h6, 10'h000, 36'h0);
    u_host.cyc(5'h0F, 4'hF, ON, 10'h021, 36'h0);
    chk("oe after deselect", 36'h0, 36'(data_oe));
    u_host.cyc(5'h0F, 4'hF, ON, 10'h022, 36'h0);
    chk("oe first read", 36'h0, 36'(data_oe));
    chk("first read", wv(10'h021), q);
    u_host.nop();
    chk("oe second read", 36'h1, 36'(data_oe));
    chk("second read", wv(10'h022), q);
    // Output enable acts without the clock: look before the next rising edge
    output_enable_n = 1'b1;
    #1 chk("oe high", 36'h0, 36'(data_oe));
    @(negedge clk);
    output_enable_n = 1'b0;
  endtask : t_first
  task automatic wt(input logic v);
    for (int i = 0; i < 8 && sleeping !== v; i++) @(negedge clk);
    chk("sleeping", 36'(v), 36'(sleeping));
    if (sleeping !== v) results();
    else repeat (4) @(negedge clk);
  endtask : wt
  task automatic t_sleep();
    sleep_req = 1'b1;
    wt(1'b1);
    sleep_req = 1'b0;
    wt(1'b0);
    rd("after sleep", 10'h023, wv(10'h023));
  endtask : t_sleep
  task automatic results();
    $display("Checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // Reset, then each scenario in turn
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_fill();
    t_bytes();
    t_sel();
    t_both();
    t_burst(1'b0);
    t_burst(1'b1);
    t_first();
    t_sleep();
    results();
  end
endmodule : pbs_port_bench

bind pbs_port pbs_port_monitor u_mon (.*);
